// ==== hw/ctm_counter.sv ====
// Eight-bit binary up-counter advanced by the 256 Hz tick.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ctm_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clock, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic tick, // Count enable pulse.
  input wire logic clear, // Clear pulse.
  output logic [WIDTH-1:0] count // Counter value.
);
  import ctm_pkg::*;
  if (WIDTH != 8) begin : g_bad_width
    $error("ctm_counter: WIDTH must be 8");
  end
  // ==========================================================================
  // Counter
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count <= CTM_COUNT_RESET;
    end else if (clear) begin
      count <= CTM_COUNT_RESET;
    end else if (tick) begin
      count <= count + WIDTH'(1);
    end
  end
endmodule : ctm_counter
`default_nettype wire

// ==== hw/ctm_pkg.sv ====
// Package for the clock timer control block: register map, field layout, reset values and timing counts.
// Assumes a 4-bit register port with 12-bit addresses and a single 40 MHz clock.
package ctm_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] CTM_ADDR_FLAGS = 12'hf00;
  localparam logic [11:0] CTM_ADDR_ENABLE = 12'hf10;
  localparam logic [11:0] CTM_ADDR_COUNT_LO = 12'hf20;
  localparam logic [11:0] CTM_ADDR_COUNT_HI = 12'hf21;
  localparam logic [11:0] CTM_ADDR_CONTROL = 12'hf76;
  // ==========================================================================
  // Field layout
  localparam int CTM_BIT_WDOG_CLEAR = 0;
  localparam int CTM_BIT_COUNT_CLEAR = 1;
  // Counter bit positions feeding the tick flags (32, 8, 2, 1 Hz).
  localparam int CTM_CNT_BIT_32HZ = 2;
  localparam int CTM_CNT_BIT_8HZ = 4;
  localparam int CTM_CNT_BIT_2HZ = 6;
  localparam int CTM_CNT_BIT_1HZ = 7;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTM_COUNT_RESET = 8'h00;
  localparam logic [3:0] CTM_FLAGS_RESET = 4'h0;
  localparam logic [3:0] CTM_ENABLE_RESET = 4'h0;
  // ==========================================================================
  // Timing
  localparam longint CTM_CLOCK_HZ = 40000000;
  localparam longint CTM_TICK_HZ = 256;
  localparam int CTM_TICK_CYCLES = int'(CTM_CLOCK_HZ / CTM_TICK_HZ);
endpackage : ctm_pkg

// ==== hw/ctm_tick_gen.sv ====
// Tick generator: divides the system clock down to the 256 Hz counter tick.
// Assumes the divide ratio fits in 32 bits; the restart input restarts the phase.
`timescale 1ns/10ps
`default_nettype none
module ctm_tick_gen #(
  parameter int DIVIDE = ctm_pkg::CTM_TICK_CYCLES
) (
  input wire logic clock, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic restart, // Restart the divider phase.
  output logic tick // One-cycle tick pulse.
);
  import ctm_pkg::*;
  logic [31:0] div_reg;
  if (DIVIDE < 2) begin : g_bad_divide
    $error("ctm_tick_gen: DIVIDE must be at least 2");
  end
  // ==========================================================================
  // Divider
  always_ff @(posedge clock) begin
    if (!rst_b || restart) begin
      div_reg <= 32'h0;
      tick <= 1'b0;
    end else if (div_reg == 32'(DIVIDE - 1)) begin
      div_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : ctm_tick_gen
`default_nettype wire

// ==== hw/ctm_timer.sv ====
// Clock timer control: counter readout, clear strobe, tick flags, enables and interrupt request.
// Assumes a single-cycle read/write strobe port from the CPU core and read data one cycle later.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module ctm_timer #(
  parameter int TICK_DIVIDE = ctm_pkg::CTM_TICK_CYCLES
) (
  input wire logic clock, // 40 MHz system clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic [11:0] addr, // Register address.
  input wire logic [3:0] wdata, // Write data.
  input wire logic wr_stb, // Write strobe.
  input wire logic rd_stb, // Read strobe.
  output logic [3:0] rdata, // Read data, valid the cycle after rd_stb.
  output logic timer_irq, // Interrupt request to the core.
  output logic watchdog_clear_strobe // Pulse to the watchdog.
);
  import ctm_pkg::*;

  if (TICK_DIVIDE < 2) begin : g_bad_divide
    $error("ctm_timer: TICK_DIVIDE must be at least 2");
  end

  logic tick;
  logic count_clear;
  logic [7:0] count;
  logic [3:0] taps;
  logic [3:0] taps_reg;
  logic [3:0] tick_flag_bank_reg;
  logic [3:0] tick_enable_bank_reg;
  logic [3:0] rdata_next;
  logic flag_read;

  // ==========================================================================
  // Register decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  assign count_clear = wr_stb && hit(addr, CTM_ADDR_CONTROL) && wdata[CTM_BIT_COUNT_CLEAR];
  assign flag_read = rd_stb && hit(addr, CTM_ADDR_FLAGS);

  // ==========================================================================
  // Tick and counter
  // Restarting the divider on clear gives a full tick period after the clear.
  ctm_tick_gen #(.DIVIDE(TICK_DIVIDE)) u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .restart(count_clear),
    .tick(tick)
  );

  ctm_counter #(.WIDTH(8)) u_count (
    .clock(clock),
    .rst_b(rst_b),
    .tick(tick),
    .clear(count_clear),
    .count(count)
  );

  // ==========================================================================
  // Tick flags
  assign taps = {count[CTM_CNT_BIT_1HZ], count[CTM_CNT_BIT_2HZ], count[CTM_CNT_BIT_8HZ], count[CTM_CNT_BIT_32HZ]};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      taps_reg <= 4'h0;
    end else begin
      taps_reg <= taps;
    end
  end

  // A clear that drops a high tapped counter bit (2, 4, 6 or 7) looks like a falling edge and sets that bit's flag.
  // A set in the same cycle as the clearing read wins, so no event is lost.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_flag_bank_reg <= CTM_FLAGS_RESET;
    end else begin
      tick_flag_bank_reg <= (flag_read ? 4'h0 : tick_flag_bank_reg) | (taps_reg & ~taps);
    end
  end

  // ==========================================================================
  // Enables
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_enable_bank_reg <= CTM_ENABLE_RESET;
    end else if (wr_stb && hit(addr, CTM_ADDR_ENABLE)) begin
      tick_enable_bank_reg <= wdata;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(tick_flag_bank_reg & tick_enable_bank_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      watchdog_clear_strobe <= 1'b0;
    end else begin
      watchdog_clear_strobe <= wr_stb && hit(addr, CTM_ADDR_CONTROL) && wdata[CTM_BIT_WDOG_CLEAR];
    end
  end

  // Counter nibbles have no write path at all.
  always_comb begin
    rdata_next = 4'h0;
    if (hit(addr, CTM_ADDR_FLAGS)) begin
      rdata_next = tick_flag_bank_reg;
    end else if (hit(addr, CTM_ADDR_ENABLE)) begin
      rdata_next = tick_enable_bank_reg;
    end else if (hit(addr, CTM_ADDR_COUNT_LO)) begin
      rdata_next = count[3:0];
    end else if (hit(addr, CTM_ADDR_COUNT_HI)) begin
      rdata_next = count[7:4];
    end else if (hit(addr, CTM_ADDR_CONTROL)) begin
      rdata_next = 4'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata <= 4'h0;
    end else begin
      rdata <= rd_stb ? rdata_next : 4'h0;
    end
  end

  // ==========================================================================
  // Assertions
  property p_count_clear;
    @(posedge clock) disable iff (!rst_b) count_clear |=> (count == 8'h00);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

  property p_count_hold;
    @(posedge clock) disable iff (!rst_b) (!tick && !count_clear) |=> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without tick");

  property p_count_step;
    @(posedge clock) disable iff (!rst_b) (tick && !count_clear) |=> (count == $past(count) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_flag_set;
    @(posedge clock) disable iff (!rst_b) (taps_reg[0] && !taps[0]) |=> tick_flag_bank_reg[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("32 Hz flag missed");

  property p_flag_read_clear;
    @(posedge clock) disable iff (!rst_b) (flag_read && (taps_reg == taps)) |=> (tick_flag_bank_reg == 4'h0);
  endproperty
  a_flag_read_clear: assert property (p_flag_read_clear) else $error("flags not cleared by read");

  property p_read_data;
    @(posedge clock) disable iff (!rst_b) (rd_stb && hit(addr, CTM_ADDR_COUNT_HI)) |=> (rdata == $past(count[7:4]));
  endproperty
  a_read_data: assert property (p_read_data) else $error("high nibble readback wrong");

  property p_clear_reads_zero;
    @(posedge clock) disable iff (!rst_b) (rd_stb && hit(addr, CTM_ADDR_CONTROL)) |=> (rdata == 4'h0);
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("control read not zero");

  property p_irq;
    @(posedge clock) disable iff (!rst_b) |(tick_flag_bank_reg & tick_enable_bank_reg) |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_enable_write;
    @(posedge clock) disable iff (!rst_b) (wr_stb && hit(addr, CTM_ADDR_ENABLE)) |=> (tick_enable_bank_reg == $past(wdata));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_flag_set_8hz;
    @(posedge clock) disable iff (!rst_b) (taps_reg[1] && !taps[1]) |=> tick_flag_bank_reg[1];
  endproperty
  a_flag_set_8hz: assert property (p_flag_set_8hz) else $error("8 Hz flag missed");

  property p_flag_set_2hz;
    @(posedge clock) disable iff (!rst_b) (taps_reg[2] && !taps[2]) |=> tick_flag_bank_reg[2];
  endproperty
  a_flag_set_2hz: assert property (p_flag_set_2hz) else $error("2 Hz flag missed");

  property p_flag_set_1hz;
    @(posedge clock) disable iff (!rst_b) (taps_reg[3] && !taps[3]) |=> tick_flag_bank_reg[3];
  endproperty
  a_flag_set_1hz: assert property (p_flag_set_1hz) else $error("1 Hz flag missed");

  property p_flag_no_spurious;
    @(posedge clock) disable iff (!rst_b)
      ((taps_reg & ~taps) == 4'h0) |=> ((tick_flag_bank_reg & ~$past(tick_flag_bank_reg)) == 4'h0);
  endproperty
  a_flag_no_spurious: assert property (p_flag_no_spurious) else $error("flag set without falling edge");

  property p_flag_hold;
    @(posedge clock) disable iff (!rst_b)
      !flag_read |=> ((tick_flag_bank_reg & $past(tick_flag_bank_reg)) == $past(tick_flag_bank_reg));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a read");

  property p_flag_write_ignored;
    @(posedge clock) disable iff (!rst_b)
      (wr_stb && hit(addr, CTM_ADDR_FLAGS) && !flag_read && (taps_reg == taps)) |=> $stable(tick_flag_bank_reg);
  endproperty
  a_flag_write_ignored: assert property (p_flag_write_ignored) else $error("flag write took effect");

  property p_clear_flag_side;
    @(posedge clock) disable iff (!rst_b) (count_clear && count[CTM_CNT_BIT_32HZ]) |=> ##1 tick_flag_bank_reg[0];
  endproperty
  a_clear_flag_side: assert property (p_clear_flag_side) else $error("clear edge did not set flag");

  property p_count_write_ignored;
    @(posedge clock) disable iff (!rst_b)
      (wr_stb && (hit(addr, CTM_ADDR_COUNT_LO) || hit(addr, CTM_ADDR_COUNT_HI)) && !tick) |=> $stable(count);
  endproperty
  a_count_write_ignored: assert property (p_count_write_ignored) else $error("counter write took effect");

  property p_clear_zero_noop;
    @(posedge clock) disable iff (!rst_b)
      (wr_stb && hit(addr, CTM_ADDR_CONTROL) && !wdata[CTM_BIT_COUNT_CLEAR] && !tick) |=> $stable(count);
  endproperty
  a_clear_zero_noop: assert property (p_clear_zero_noop) else $error("zero write moved counter");

  property p_clear_restarts;
    @(posedge clock) disable iff (!rst_b) count_clear |=> !tick;
  endproperty
  a_clear_restarts: assert property (p_clear_restarts) else $error("tick right after clear");

  property p_tick_pulse;
    @(posedge clock) disable iff (!rst_b) tick |=> !tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

  property p_read_low;
    @(posedge clock) disable iff (!rst_b) (rd_stb && hit(addr, CTM_ADDR_COUNT_LO)) |=> (rdata == $past(count[3:0]));
  endproperty
  a_read_low: assert property (p_read_low) else $error("low nibble readback wrong");

  property p_read_flags;
    @(posedge clock) disable iff (!rst_b) (rd_stb && hit(addr, CTM_ADDR_FLAGS)) |=> (rdata == $past(tick_flag_bank_reg));
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag readback wrong");

  property p_read_enable;
    @(posedge clock) disable iff (!rst_b) (rd_stb && hit(addr, CTM_ADDR_ENABLE)) |=> (rdata == $past(tick_enable_bank_reg));
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable readback wrong");

  property p_enable_hold;
    @(posedge clock) disable iff (!rst_b) !(wr_stb && hit(addr, CTM_ADDR_ENABLE)) |=> $stable(tick_enable_bank_reg);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enables moved without a write");

  property p_irq_low;
    @(posedge clock) disable iff (!rst_b) !(|(tick_flag_bank_reg & tick_enable_bank_reg)) |=> !timer_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt without enabled flag");

  property p_enable_masks;
    @(posedge clock) disable iff (!rst_b) (tick_enable_bank_reg == 4'h0) |=> !timer_irq;
  endproperty
  a_enable_masks: assert property (p_enable_masks) else $error("masked interrupt raised");

  property p_count_reset;
    @(posedge clock) !rst_b |=> (count == CTM_COUNT_RESET);
  endproperty
  a_count_reset: assert property (p_count_reset) else $error("counter not reset");

  property p_flags_reset;
    @(posedge clock) !rst_b |=> (tick_flag_bank_reg == CTM_FLAGS_RESET);
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("flags not reset");

  property p_enable_reset;
    @(posedge clock) !rst_b |=> (tick_enable_bank_reg == CTM_ENABLE_RESET);
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enables not reset");

  property p_irq_reset;
    @(posedge clock) !rst_b |=> !timer_irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("interrupt high after reset");
endmodule : ctm_timer
`default_nettype wire

// ==== verification/ctm_cpu_model.sv ====
// Model of the 4-bit core's data bus side: one-cycle read and write strobes.
// Assumes the timer answers a read in the cycle after the strobe and never stalls.
`timescale 1ns/10ps
`default_nettype none
module ctm_cpu_model (
  input wire logic clock, // System clock.
  input wire logic [3:0] rdata, // Read data from the timer.
  output logic [11:0] addr, // Register address.
  output logic [3:0] wdata, // Write data.
  output logic wr_stb, // Write strobe.
  output logic rd_stb // Read strobe.
);
  // ==========================================================================
  // Bus cycles
  // Callers keep the core's interrupts off, so enable writes and flag reads are safe.
  logic interrupts_off_state;
  initial begin
    interrupts_off_state = 1'b1;
    addr = 12'h000;
    wdata = 4'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // Released lines show the inverse, so a stale value can never pass as fresh.
  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [3:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask : rd
endmodule : ctm_cpu_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for ctm_timer, driven through the core bus model.
// Assumes a divide of 4 clocks per counter tick.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ctm_pkg::*;
  logic clock, rst_b, wr_stb, rd_stb, timer_irq, wdog;
  logic [11:0] addr;
  logic [3:0] wdata, rdata, d;
  int miscompares = 0;
  int tests_run = 0;
  ctm_timer #(.TICK_DIVIDE(4)) ctm_timer_i (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_irq(timer_irq), .watchdog_clear_strobe(wdog));
  ctm_cpu_model ctm_cpu_model_i (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ==========================================================================
  // Helpers
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic gap(input int n);
    repeat (n) @(posedge clock);
  endtask : gap
  task automatic rc(input logic [11:0] a, input logic [3:0] exp);
    ctm_cpu_model_i.rd(a, d);
    check(d, exp);
  endtask : rc
  // Clears counter and watchdog together, then drops any flag the clear raised.
  task automatic clr();
    ctm_cpu_model_i.wr(CTM_ADDR_CONTROL, 4'h3);
    #1 check(4'(wdog), 4'h1);
    gap(4);
    ctm_cpu_model_i.rd(CTM_ADDR_FLAGS, d);
  endtask : clr
  // ==========================================================================
  // Tests
  initial begin
    rst_b = 1'b0;
    gap(6);
    rst_b <= 1'b1;
    rc(CTM_ADDR_COUNT_HI, 4'h0);
    rc(CTM_ADDR_FLAGS, 4'h0);
    rc(CTM_ADDR_ENABLE, 4'h0);
    rc(12'h123, 4'h0);
    ctm_cpu_model_i.wr(CTM_ADDR_ENABLE, 4'ha);
    rc(CTM_ADDR_ENABLE, 4'ha);
    ctm_cpu_model_i.wr(CTM_ADDR_ENABLE, 4'h5);
    rc(CTM_ADDR_ENABLE, 4'h5);
    ctm_cpu_model_i.wr(CTM_ADDR_ENABLE, 4'h0);
    clr();
    gap(352);
    // High nibble is read mid-span so no carry can split the pair.
    rc(CTM_ADDR_COUNT_HI, 4'h5);
    ctm_cpu_model_i.rd(CTM_ADDR_COUNT_LO, d);
    check(4'(d >= 4'h7 && d <= 4'ha), 4'h1);
    ctm_cpu_model_i.wr(CTM_ADDR_CONTROL, 4'h0);
    #1 check(4'(wdog), 4'h0);
    rc(CTM_ADDR_COUNT_HI, 4'h5);
    rc(CTM_ADDR_CONTROL, 4'h0);
    ctm_cpu_model_i.wr(CTM_ADDR_COUNT_HI, 4'hf);
    ctm_cpu_model_i.wr(CTM_ADDR_COUNT_LO, 4'hf);
    rc(CTM_ADDR_COUNT_HI, 4'h5);
    clr();
    rc(CTM_ADDR_COUNT_HI, 4'h0);
    gap(132);
    rc(CTM_ADDR_FLAGS, 4'h3);
    rc(CTM_ADDR_FLAGS, 4'h0);
    ctm_cpu_model_i.wr(CTM_ADDR_FLAGS, 4'hf);
    rc(CTM_ADDR_FLAGS, 4'h0);
    gap(890);
    #1 check(4'(timer_irq), 4'h0);
    rc(CTM_ADDR_FLAGS, 4'hf);
    ctm_cpu_model_i.wr(CTM_ADDR_ENABLE, 4'h1);
    clr();
    // The request follows the flags one cycle late, so the clear's stray flag shows until then.
    gap(1);
    #1 check(4'(timer_irq), 4'h0);
    gap(32);
    #1 check(4'(timer_irq), 4'h1);
    rc(CTM_ADDR_FLAGS, 4'h1);
    gap(2);
    #1 check(4'(timer_irq), 4'h0);
    gap(25);
    #1 check(4'(timer_irq), 4'h1);
    ctm_cpu_model_i.wr(CTM_ADDR_ENABLE, 4'h0);
    gap(2);
    #1 check(4'(timer_irq), 4'h0);
    rc(CTM_ADDR_FLAGS, 4'h1);
    ctm_cpu_model_i.wr(CTM_ADDR_ENABLE, 4'hf);
    rst_b <= 1'b0;
    gap(2);
    rst_b <= 1'b1;
    rc(CTM_ADDR_ENABLE, 4'h0);
    rc(CTM_ADDR_COUNT_HI, 4'h0);
    give_verdict();
  end
  // A run needs about 1530 cycles; 5000 leaves ample margin.
  initial begin
    gap(5000);
    miscompares++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
